/* phy_mgmt_pkg.sv */
// Constants, field layouts and carriers for the layer management bank.
// Assumes a single core clock and a plain strobe register port.
package phy_mgmt_pkg;

	localparam int ADDR_W = 8;                  // Register address width.
	localparam int DATA_W = 32;                 // Register data width.
	localparam int COEF_W = 6;                  // Width of one tap setting.

	// Byte offsets of the common registers.
	localparam logic [7:0] OFS_KIND     = 8'h00;
	localparam logic [7:0] OFS_STATE    = 8'h04;
	localparam logic [7:0] OFS_CTRL     = 8'h08;
	localparam logic [7:0] OFS_CAP      = 8'h0C;
	localparam logic [7:0] OFS_SLEEP    = 8'h10;
	localparam logic [7:0] OFS_ACTSLEEP = 8'h14;

	// Per-lane regions, selected by address bits 7:5; bits 4:2 pick the lane.
	localparam logic [2:0] RGN_TXCTL = 3'h1;
	localparam logic [2:0] RGN_TXSTS = 3'h2;
	localparam logic [2:0] RGN_RXSTS = 3'h3;

	localparam logic [3:0] KIND_CODE = 4'h5;    // Layer kind of this clause.

	// Link state encodings.
	localparam logic [3:0] ST_DOWN    = 4'h0;
	localparam logic [3:0] ST_UP      = 4'h1;
	localparam logic [3:0] ST_RETRAIN = 4'h2;
	localparam logic [3:0] ST_SLEEP1  = 4'h7;
	localparam logic [3:0] ST_SLEEP2  = 4'h8;
	localparam logic [3:0] ST_UPSLEEP = 4'hB;

	localparam logic [1:0] ARC_ONE     = 2'h0;  // Retraining arc one.
	localparam logic [1:0] ARC_TWO     = 2'h1;  // Retraining arc two.
	localparam logic [1:0] MODE_AUTO   = 2'h0;  // In-band coefficient exchange.
	localparam logic [1:0] MODE_DIRECT = 2'h1;  // Direct management control.

	// One set of transmit taps; no second pre-cursor exists.
	typedef struct packed {
		logic [COEF_W-1:0] post;
		logic [COEF_W-1:0] main;
		logic [COEF_W-1:0] pre1;
	} coef_s;

	// Register port request.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} reg_req_s;

	typedef struct packed {
		logic [23:0] rsv;
		logic [3:0]  prev;
		logic [3:0]  cur;
	} state_s;

	typedef struct packed {
		logic [22:0] rsv1;
		logic        chanOpt;
		logic [5:0]  rsv0;
		logic [1:0]  arc;
	} ctrl_s;

	typedef struct packed {
		logic [23:0] rsv1;
		logic [3:0]  farAsym;
		logic [1:0]  rsv0;
		logic        asymRev;
		logic        arc34;
	} cap_s;

	typedef struct packed {
		logic [15:0] rsv1;
		logic [7:0]  highLat;
		logic [5:0]  rsv0;
		logic        highSup;
		logic        lowSup;
	} sleep_s;

	// Transmit lane control and status share one layout.
	typedef struct packed {
		logic [1:0]        rsvC;
		logic [COEF_W-1:0] post;
		logic [1:0]        rsvB;
		logic [COEF_W-1:0] main;
		logic [1:0]        rsvA;
		logic [COEF_W-1:0] pre1;
		logic [5:0]        rsv0;
		logic [1:0]        mode;
	} txlane_s;

	typedef struct packed {
		logic [12:0] rsv;
		logic        chgReq;
		coef_s       req;
	} rxsts_s;

	localparam coef_s COEF_RST = '0;            // Taps at reset.

endpackage : phy_mgmt_pkg

/* phy_mgmt_field_limits.sv */
// Management register bank fixing the reported and accepted field values.
// Assumes the training machine presents its state code every cycle and
// pulses alignEntry once as it enters the alignment state.
module phy_mgmt_field_limits #(
	parameter int  LANES       = 4,     // Number of lanes served.
	parameter bit  UPSLEEP_SUP = 1'b1,  // First active sleep state offered.
	parameter bit  SLEEP12_SUP = 1'b1   // Sleep levels one and two offered.
) (
	input  wire logic                                core_clk,   // Core clock.
	input  wire logic                                rst,        // Sync reset.
	input  wire phy_mgmt_pkg::reg_req_s              regReq,     // Register request.
	output logic [phy_mgmt_pkg::DATA_W-1:0]          rdata,      // Read data.
	input  wire logic [3:0]                          linkStateIn,// Training state code.
	input  wire logic                                alignEntry, // Alignment entry pulse.
	input  wire phy_mgmt_pkg::coef_s [LANES-1:0]     rxReqCoef,  // Far-end tap requests.
	input  wire logic [LANES-1:0]                    rxReqChg,   // Far-end change request.
	output logic [1:0]                               retrainArc, // Selected arc.
	output logic                                     chanOptEn,  // Do channel optimize.
	output logic [LANES-1:0][1:0]                    cursorMode, // Per-lane cursor mode.
	output phy_mgmt_pkg::coef_s [LANES-1:0]          txCoef      // Taps in force.
);

	// Refuse lane counts that the address map cannot hold.
	if (LANES < 1 || LANES > 8) begin : g_bad_lanes
		$error("LANES must lie between 1 and 8.");
	end

	// Address fields of the current request.
	logic [2:0] region;                 // Register region.
	logic [2:0] lane;                   // Lane index in a region.
	logic       laneOk;                 // Lane index exists.
	assign region = regReq.addr[7:5];
	assign lane   = regReq.addr[4:2];
	assign laneOk = (32'(lane) < LANES);

	// Lane index trimmed to the width that selects among the lanes.
	localparam int LIX_W = (LANES > 1) ? $clog2(LANES) : 1;
	logic [LIX_W-1:0] laneIx;           // Lane index for array selects.
	assign laneIx = LIX_W'(lane % LANES);

	// Link state and control registers.
	logic [3:0] curQ,  curD;            // Current state code.
	logic [3:0] prevQ, prevD;           // Previous state code.
	logic [1:0] arcQ,  arcD;            // Retraining arc.
	logic       optQ,  optD;            // Channel optimize enable.
	logic       legalIn;                // Incoming code is assigned.
	phy_mgmt_pkg::ctrl_s wrCtrl;        // Write data seen as control.

	assign wrCtrl = phy_mgmt_pkg::ctrl_s'(regReq.wdata);

	// Only assigned codes may enter the state fields.
	always_comb begin
		case (linkStateIn)
			phy_mgmt_pkg::ST_DOWN, phy_mgmt_pkg::ST_UP,
			phy_mgmt_pkg::ST_RETRAIN, phy_mgmt_pkg::ST_SLEEP1,
			phy_mgmt_pkg::ST_SLEEP2, phy_mgmt_pkg::ST_UPSLEEP: begin
				legalIn = 1'b1;
			end
			default: begin
				legalIn = 1'b0;
			end
		endcase
	end

	// Next values for the state and control fields.
	always_comb begin
		curD  = curQ;
		prevD = prevQ;
		arcD  = arcQ;
		optD  = optQ;
		// A new state pushes the old one into the previous field.
		if (legalIn && linkStateIn != curQ) begin
			curD  = linkStateIn;
			prevD = curQ;
		end
		if (regReq.wr && regReq.addr == phy_mgmt_pkg::OFS_CTRL) begin
			// Reserved arc codes are dropped so the arc stays legal.
			if (wrCtrl.arc == phy_mgmt_pkg::ARC_ONE ||
			    wrCtrl.arc == phy_mgmt_pkg::ARC_TWO) begin
				arcD = wrCtrl.arc;
			end
			optD = wrCtrl.chanOpt;
		end
	end

	// State and control registers; reset leaves the link down and bypassed.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			curQ  <= phy_mgmt_pkg::ST_DOWN;
			prevQ <= phy_mgmt_pkg::ST_DOWN;
			arcQ  <= phy_mgmt_pkg::ARC_ONE;
			optQ  <= 1'b0;
		end else begin
			curQ  <= curD;
			prevQ <= prevD;
			arcQ  <= arcD;
			optQ  <= optD;
		end
	end

	assign retrainArc = arcQ;
	assign chanOptEn  = optQ;

	// Per-lane transmit control and the taps actually in force.
	logic [LANES-1:0][1:0]        modeQ;    // Cursor mode per lane.
	phy_mgmt_pkg::coef_s [LANES-1:0] progQ; // Programmed taps.
	phy_mgmt_pkg::coef_s [LANES-1:0] liveQ; // Taps in force.
	phy_mgmt_pkg::txlane_s wrLane;          // Write data seen as a lane word.

	assign wrLane = phy_mgmt_pkg::txlane_s'(regReq.wdata);

	for (genvar i = 0; i < LANES; i++) begin : g_lane
		logic [1:0]          modeD; // Next cursor mode.
		phy_mgmt_pkg::coef_s progD; // Next programmed taps.
		phy_mgmt_pkg::coef_s liveD; // Next taps in force.
		logic                hit;   // This lane's control is written.

		assign hit = regReq.wr && region == phy_mgmt_pkg::RGN_TXCTL &&
		             32'(lane) == i && regReq.addr[1:0] == 2'b00;

		// Writes stage taps; they go live at alignment entry.
		always_comb begin
			modeD = modeQ[i];
			progD = progQ[i];
			liveD = liveQ[i];
			if (hit) begin
				// Reserved mode codes are ignored.
				if (wrLane.mode == phy_mgmt_pkg::MODE_AUTO ||
				    wrLane.mode == phy_mgmt_pkg::MODE_DIRECT) begin
					modeD = wrLane.mode;
				end
				progD.pre1 = wrLane.pre1;
				progD.main = wrLane.main;
				progD.post = wrLane.post;
			end
			if (alignEntry) begin
				liveD = progQ[i];
			end
		end

		// Lane registers; the mode starts in direct control.
		always_ff @(posedge core_clk) begin
			if (rst) begin
				modeQ[i] <= phy_mgmt_pkg::MODE_DIRECT;
				progQ[i] <= phy_mgmt_pkg::COEF_RST;
				liveQ[i] <= phy_mgmt_pkg::COEF_RST;
			end else begin
				modeQ[i] <= modeD;
				progQ[i] <= progD;
				liveQ[i] <= liveD;
			end
		end
	end

	assign cursorMode = modeQ;
	assign txCoef     = liveQ;

	// Fixed words and read assembly.
	phy_mgmt_pkg::state_s  stWord;   // State report word.
	phy_mgmt_pkg::ctrl_s   ctWord;   // Control word.
	phy_mgmt_pkg::cap_s    capWord;  // Capability word.
	phy_mgmt_pkg::sleep_s  slpWord;  // Sleep support word.
	phy_mgmt_pkg::sleep_s  actWord;  // Active sleep support word.
	phy_mgmt_pkg::txlane_s txcWord;  // Lane control word.
	phy_mgmt_pkg::txlane_s txsWord;  // Lane status word.
	phy_mgmt_pkg::rxsts_s  rxsWord;  // Lane receive status word.
	logic [phy_mgmt_pkg::DATA_W-1:0] rdD, rdQ; // Read data.

	// Build every readable word but the kind code; unlisted fields read zero.
	always_comb begin
		stWord          = '0;
		stWord.cur      = curQ;
		stWord.prev     = prevQ;
		ctWord          = '0;
		ctWord.arc      = arcQ;
		ctWord.chanOpt  = optQ;
		capWord         = '0;
		capWord.arc34   = 1'b0;
		capWord.asymRev = 1'b0;
		capWord.farAsym = 4'h0;
		slpWord         = '0;
		slpWord.lowSup  = SLEEP12_SUP;
		slpWord.highSup = 1'b0;
		slpWord.highLat = 8'h00;
		actWord         = '0;
		actWord.lowSup  = UPSLEEP_SUP;
		actWord.highSup = 1'b0;
		actWord.highLat = 8'h00;
		// The second pre-cursor has no bits in these words.
		txcWord         = '0;
		txcWord.mode    = modeQ[laneIx];
		txcWord.pre1    = progQ[laneIx].pre1;
		txcWord.main    = progQ[laneIx].main;
		txcWord.post    = progQ[laneIx].post;
		txsWord         = '0;
		txsWord.mode    = modeQ[laneIx];
		txsWord.pre1    = liveQ[laneIx].pre1;
		txsWord.main    = liveQ[laneIx].main;
		txsWord.post    = liveQ[laneIx].post;
		rxsWord         = '0;
		rxsWord.req     = rxReqCoef[laneIx];
		rxsWord.chgReq  = rxReqChg[laneIx];
	end

	// Read decode; unmapped addresses return zero.
	always_comb begin
		rdD = '0;
		if (!regReq.rd) begin
			rdD = '0;
		end else if (regReq.addr == phy_mgmt_pkg::OFS_KIND) begin
			rdD = 32'(phy_mgmt_pkg::KIND_CODE);
		end else if (regReq.addr == phy_mgmt_pkg::OFS_STATE) begin
			rdD = stWord;
		end else if (regReq.addr == phy_mgmt_pkg::OFS_CTRL) begin
			rdD = ctWord;
		end else if (regReq.addr == phy_mgmt_pkg::OFS_CAP) begin
			rdD = capWord;
		end else if (regReq.addr == phy_mgmt_pkg::OFS_SLEEP) begin
			rdD = slpWord;
		end else if (regReq.addr == phy_mgmt_pkg::OFS_ACTSLEEP) begin
			rdD = actWord;
		end else if (!laneOk || regReq.addr[1:0] != 2'b00) begin
			rdD = '0;
		end else if (region == phy_mgmt_pkg::RGN_TXCTL) begin
			rdD = txcWord;
		end else if (region == phy_mgmt_pkg::RGN_TXSTS) begin
			rdD = txsWord;
		end else if (region == phy_mgmt_pkg::RGN_RXSTS) begin
			rdD = rxsWord;
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdQ <= '0;
		end else begin
			rdQ <= rdD;
		end
	end

	assign rdata = rdQ;

	// Checks on the design's own state registers and outputs.
	sequence s_kind_read;
		regReq.rd && regReq.addr == phy_mgmt_pkg::OFS_KIND;
	endsequence

	sequence s_lane0_write;
		regReq.wr && regReq.addr == {phy_mgmt_pkg::RGN_TXCTL, 5'h00};
	endsequence

	a_kind_fixed: assert property (@(posedge core_clk) disable iff (rst)
		s_kind_read |=> rdata == 32'h0000_0005)
		else $error("Layer kind read wrong.");

	a_state_legal: assert property (@(posedge core_clk) disable iff (rst)
		legalIn && linkStateIn != curQ |=> curQ == $past(linkStateIn))
		else $error("Current state not taken.");

	a_prev_tracks: assert property (@(posedge core_clk) disable iff (rst)
		$changed(curQ) && !$past(rst) |-> prevQ == $past(curQ))
		else $error("Previous state lost.");

	a_arc_legal: assert property (@(posedge core_clk) disable iff (rst)
		retrainArc == phy_mgmt_pkg::ARC_ONE || retrainArc == phy_mgmt_pkg::ARC_TWO)
		else $error("Illegal retrain arc.");

	a_cap_zero: assert property (@(posedge core_clk) disable iff (rst)
		regReq.rd && regReq.addr == phy_mgmt_pkg::OFS_CAP |=> rdata == 32'h0000_0000)
		else $error("Capability bits not zero.");

	a_sleep_high: assert property (@(posedge core_clk) disable iff (rst)
		regReq.rd && regReq.addr == phy_mgmt_pkg::OFS_SLEEP |=> rdata[23:1] == '0)
		else $error("Sleep three four reported.");

	a_actsleep_high: assert property (@(posedge core_clk) disable iff (rst)
		regReq.rd && regReq.addr == phy_mgmt_pkg::OFS_ACTSLEEP |=> rdata[23:1] == '0)
		else $error("Active sleep two to four reported.");

	a_mode_reset: assert property (@(posedge core_clk)
		rst |=> cursorMode[0] == phy_mgmt_pkg::MODE_DIRECT)
		else $error("Cursor mode reset wrong.");

	a_opt_reset: assert property (@(posedge core_clk)
		rst |=> !chanOptEn)
		else $error("Channel optimize not bypassed.");

	a_coef_align: assert property (@(posedge core_clk) disable iff (rst)
		s_lane0_write ##1 (!regReq.wr)[*1] ##0 alignEntry
		|=> txCoef[0].main == $past(regReq.wdata[21:16], 2))
		else $error("Taps not applied at alignment.");

	a_tap_hold: assert property (@(posedge core_clk) disable iff (rst)
		!$past(alignEntry) && !$past(rst) |-> $stable(txCoef))
		else $error("Taps moved outside alignment.");

endmodule : phy_mgmt_field_limits

/* train_partner.sv */
// Behavioural model of the link training side that faces the management bank.
// Assumes the bench commands state codes and alignment entry on core clock edges.
module train_partner #(
	parameter int LANES = 4                                  // Lanes presented.
) (
	input  wire logic                        clk,         // Core clock.
	input  wire logic                        rst,         // Sync reset, active high.
	input  wire logic [3:0]                  stateReq,    // Commanded state code.
	input  wire logic                        alignReq,    // Request alignment entry.
	input  wire logic [5:0]                  reqBase,     // Base of far-end requests.
	output logic [3:0]                       linkState,   // State code presented.
	output logic                             alignPulse,  // One-cycle alignment entry.
	output phy_mgmt_pkg::coef_s [LANES-1:0]  reqCoef,     // Far-end tap requests.
	output logic [LANES-1:0]                 reqChg       // Far-end change flags.
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] state_q, state_d;  // Presented state code.
	logic       align_q, align_d;  // Alignment entry pulse.

	// Next state follows the command; alignment entry is a single-cycle pulse.
	always_comb begin
		state_d = stateReq;
		align_d = alignReq & ~align_q;
	end

	// Registers change just after the edge, like the real training machine.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= phy_mgmt_pkg::ST_DOWN;
			align_q <= 1'b0;
		end else begin
			state_q <= state_d;
			align_q <= align_d;
		end
	end

	assign linkState  = state_q;
	assign alignPulse = align_q;

	// Far-end requests differ per lane so a lane mix-up shows at once.
	always_comb begin
		for (int l = 0; l < LANES; l++) begin
			reqCoef[l].post = reqBase + 6'(l);
			reqCoef[l].main = 6'(l);
			reqCoef[l].pre1 = reqBase;
			reqChg[l]       = 1'(l % 2);
		end
	end

endmodule : train_partner

/* phy_mgmt_field_limits_tb.sv */
// Self-checking bench for the layer management register bank.
// Assumes the default parameters: four lanes, both sleep support bits set.
module phy_mgmt_field_limits_tb;
	timeunit 1ns;
	timeprecision 100ps;

	typedef struct packed {
		logic        wr;    // Write row when set, else read and compare.
		logic [7:0]  addr;  // Byte address.
		logic [31:0] data;  // Write data or expected read data.
	} row_s;

	logic                                coreClk = 1'b0;  // Core clock.
	logic                                rst     = 1'b1;  // Sync reset.
	phy_mgmt_pkg::reg_req_s              req     = '0;    // Register request.
	logic [31:0]                         rdata;           // Read data.
	logic [3:0]                          stateReq = 4'h0; // Commanded state.
	logic                                alignReq = 1'b0; // Alignment command.
	logic [3:0]                          linkState;       // Partner state code.
	logic                                alignPulse;      // Partner alignment pulse.
	phy_mgmt_pkg::coef_s [3:0]           reqCoef;         // Far-end requests.
	logic [3:0]                          reqChg;          // Far-end change flags.
	logic [1:0]                          retrainArc;      // Selected arc.
	logic                                chanOptEn;       // Channel optimize enable.
	logic [3:0][1:0]                     cursorMode;      // Per-lane mode.
	phy_mgmt_pkg::coef_s [3:0]           txCoef;          // Taps in force.
	int                                  n_fail      = 0; // Mismatch count.
	int                                  comparisons = 0; // Comparison count.
	int                                  cycles      = 0; // Timeout counter.
	logic [3:0]                          expCur, expPrev; // Expected state codes.
	row_s                                rows [20];       // Ordinary cases.
	logic [3:0]                          codes [9];       // State code sequence.

	// Clock at 250 MHz.
	always #2 coreClk = ~coreClk;

	phy_mgmt_field_limits u_phy_mgmt_field_limits (
		.core_clk(coreClk), .rst(rst), .regReq(req), .rdata(rdata),
		.linkStateIn(linkState), .alignEntry(alignPulse), .rxReqCoef(reqCoef),
		.rxReqChg(reqChg), .retrainArc(retrainArc), .chanOptEn(chanOptEn),
		.cursorMode(cursorMode), .txCoef(txCoef));

	train_partner u_train_partner (
		.clk(coreClk), .rst(rst), .stateReq(stateReq), .alignReq(alignReq),
		.reqBase(6'h2C), .linkState(linkState), .alignPulse(alignPulse),
		.reqCoef(reqCoef), .reqChg(reqChg));

	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One-cycle write strobe; a clock edge passes before the next request.
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		@(posedge coreClk);
		req.addr  <= a;
		req.wdata <= d;
		req.wr    <= 1'b1;
		@(posedge coreClk);
		req.wr <= 1'b0;
	endtask : wrReg

	// One-cycle read strobe; the data stand only in the following cycle.
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge coreClk);
		req.addr <= a;
		req.rd   <= 1'b1;
		@(posedge coreClk);
		req.rd <= 1'b0;
		#1 check(rdata, exp);
	endtask : rdChk

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude

	// Cuts a hang short; the tests need well under this many cycles.
	always @(posedge coreClk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		rows = '{
			'{1'b0, 8'h00, 32'h0000_0005}, '{1'b0, 8'h04, 32'h0000_0000},
			'{1'b0, 8'h08, 32'h0000_0000}, '{1'b0, 8'h0C, 32'h0000_0000},
			'{1'b0, 8'h10, 32'h0000_0001}, '{1'b0, 8'h14, 32'h0000_0001},
			'{1'b0, 8'h20, 32'h0000_0001}, '{1'b0, 8'h40, 32'h0000_0001},
			'{1'b0, 8'h18, 32'h0000_0000}, '{1'b1, 8'h08, 32'h0000_0101}, // unmapped
			'{1'b0, 8'h08, 32'h0000_0101}, '{1'b1, 8'h08, 32'h0000_0103},
			'{1'b0, 8'h08, 32'h0000_0101}, '{1'b1, 8'h0C, 32'h0000_00FF},
			'{1'b0, 8'h0C, 32'h0000_0000}, '{1'b1, 8'h20, 32'h3F2A_1500},
			'{1'b1, 8'h20, 32'h3F2A_1502}, '{1'b0, 8'h20, 32'h3F2A_1500},
			'{1'b0, 8'h40, 32'h0000_0000}, '{1'b0, 8'h3C, 32'h0000_0000}};
		codes = '{4'h1, 4'h2, 4'h3, 4'h7, 4'h7, 4'h8, 4'h9, 4'hB, 4'h0};
		repeat (12) @(posedge coreClk);
		rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].wr)
				wrReg(rows[i].addr, rows[i].data);
			else
				rdChk(rows[i].addr, rows[i].data);
		end
		check({30'h0, cursorMode[0]}, 32'h0);
		check({31'h0, chanOptEn}, 32'h1);
		check({30'h0, retrainArc}, 32'h1);
		$display("Test table done");

		// Walks the state codes, reserved and repeated ones among them.
		expCur  = 4'h0;
		expPrev = 4'h0;
		foreach (codes[i]) begin
			@(posedge coreClk);
			stateReq <= codes[i];
			if (codes[i] inside {4'h0, 4'h1, 4'h2, 4'h7, 4'h8, 4'hB} && codes[i] != expCur) begin
				expPrev = expCur;
				expCur  = codes[i];
			end
			repeat (3) @(posedge coreClk);
			rdChk(8'h04, {24'h0, expPrev, expCur});
		end
		$display("Test link state done");

		// Alignment with a lane write landing in the same cycle as the pulse.
		@(posedge coreClk);
		alignReq <= 1'b1;
		@(posedge coreClk);
		alignReq  <= 1'b0;
		req.addr  <= 8'h24;
		req.wdata <= 32'h2101_1201;
		req.wr    <= 1'b1;
		@(posedge coreClk);
		req.wr <= 1'b0;
		#1 check(32'(txCoef[0]), {14'h0, 6'h3F, 6'h2A, 6'h15});
		check(32'(txCoef[1]), 32'h0);
		rdChk(8'h40, 32'h3F2A_1500);
		@(posedge coreClk);
		alignReq <= 1'b1;
		@(posedge coreClk);
		alignReq <= 1'b0;
		repeat (2) @(posedge coreClk);
		check(32'(txCoef[1]), {14'h0, 6'h21, 6'h01, 6'h12});
		rdChk(8'h44, 32'h2101_1201);
		// A lane 0 write just before alignment entry goes live with it.
		@(posedge coreClk);
		alignReq  <= 1'b1;
		req.addr  <= 8'h20;
		req.wdata <= 32'h0C0B_0A01;
		req.wr    <= 1'b1;
		@(posedge coreClk);
		alignReq <= 1'b0;
		req.wr   <= 1'b0;
		repeat (2) @(posedge coreClk);
		#1 check(32'(txCoef[0]), {14'h0, 6'h0C, 6'h0B, 6'h0A});
		$display("Test alignment done");

		// Receive status shows the far-end taps with no second pre-cursor.
		for (int l = 0; l < 4; l++)
			rdChk(8'(8'h60 + 4 * l), {13'h0, 1'(l % 2), 6'(6'h2C + l), 6'(l), 6'h2C});
		$display("Test receive status done");

		// Reset in mid-run brings back the documented defaults.
		@(posedge coreClk);
		rst <= 1'b1;
		repeat (2) @(posedge coreClk);
		rst <= 1'b0;
		#1 check({31'h0, chanOptEn}, 32'h0);
		check({30'h0, retrainArc}, 32'h0);
		check({30'h0, cursorMode[1]}, 32'h1);
		check(32'(txCoef[1]), 32'h0);
		rdChk(8'h08, 32'h0000_0000);
		rdChk(8'h04, 32'h0000_0000);
		$display("Test mid-run reset done");
		conclude();
	end

endmodule : phy_mgmt_field_limits_tb
